// >>> shared/bch_pkg.sv
// Purpose: Shared constants, types and register map of the bus control
//          hand-back block.
// Assumes: 50 MHz clock, APB register access, byte offsets below.
// Notes:   Notes on behaviour follow.
// Notes on behaviour
// R1: With control held, no program running and no controller task, control goes back at most 10 s after it was gained.
// R2: A bus interface clear while active drops active control at once.
// R3: When a controller task finishes with no program running, control goes back straight away.
// R4: While the program runs, its hand-over command passes control on.
// R5: The program's ownership request command sets bit 1 of the event status register.
// R6: The outside controller finds a request by service request or by polling event status bit 1.
// R7: The outside controller sends the return address first and only then passes control.
// R8: The outside controller clears status and programs the event enable to 2 and the service enable to 32.
// R9: The outside controller serial polls and counts the request only when status byte bit 5 is set.
// R10: The outside controller returns the device to local state before passing control.
// R11: Control goes back to the last accepted return address, or to address 0 if none came.
// R12: A return address must be 0 to 30, with an optional secondary address.
// R13: Control is taken only when addressed to talk and then told to take control.
// R14: The idle timer restarts on each gain of control and cannot expire during a task.
// R15: The request flag stays set until the event status register is read or cleared.
package bch_pkg;

   localparam int unsigned BCH_CLK_HZ = 50_000_000;
   localparam int unsigned BCH_IDLE_S = 10;
   localparam int unsigned BCH_IDLE_CYC = BCH_IDLE_S * BCH_CLK_HZ;
   localparam int unsigned BCH_TMR_W = 29;

   // Register byte offsets
   localparam logic [7:0] BCH_OFS_CTRL = 8'h00;
   localparam logic [7:0] BCH_OFS_STAT = 8'h04;
   localparam logic [7:0] BCH_OFS_ESR = 8'h08;
   localparam logic [7:0] BCH_OFS_ESE = 8'h0c;
   localparam logic [7:0] BCH_OFS_SRE = 8'h10;
   localparam logic [7:0] BCH_OFS_PCB = 8'h14;

   // Control register fields
   localparam int unsigned BCH_CTRL_TMR_EN = 0;
   localparam int unsigned BCH_CTRL_RELEASE = 1;
   localparam int unsigned BCH_CTRL_ERR_CLR = 2;

   // Status register fields
   localparam int unsigned BCH_STAT_ACTIVE = 0;
   localparam int unsigned BCH_STAT_ST_LO = 1;
   localparam int unsigned BCH_STAT_IFC = 3;
   localparam int unsigned BCH_STAT_PROG = 4;
   localparam int unsigned BCH_STAT_BUSY = 5;
   localparam int unsigned BCH_STAT_PCB_ERR = 6;
   localparam int unsigned BCH_STAT_TMR_EXP = 7;

   // Return address register fields
   localparam int unsigned BCH_PCB_ADDR_LO = 0;
   localparam int unsigned BCH_PCB_SEC_VLD = 8;
   localparam int unsigned BCH_PCB_SEC_LO = 16;

   // Event status and status byte bits
   localparam int unsigned BCH_ESR_RQC = 1;
   localparam int unsigned BCH_STB_ESB = 5;
   localparam int unsigned BCH_STB_RQS = 6;

   localparam logic [4:0] BCH_ADDR_MAX = 5'h1e;
   localparam logic [4:0] BCH_ADDR_DFLT = 5'h00;
   localparam logic [7:0] BCH_BYTE_ZERO = 8'h00;
   localparam logic [7:0] BCH_BYTE_ONES = 8'hff;
   localparam logic [31:0] BCH_WORD_ZERO = 32'h0000_0000;
   localparam logic [2:0] BCH_IFC_SYNC_RST = 3'h7;
   localparam logic BCH_TMR_EN_RST = 1'b1;

   typedef enum logic [1:0] {
      BCH_ST_IDLE = 2'b00,
      BCH_ST_ADDR = 2'b01,
      BCH_ST_ACT = 2'b11,
      BCH_ST_PASS = 2'b10
   } bch_state_t;

   typedef struct packed {
      logic [7:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } bch_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } bch_apb_rsp_t;

   typedef struct packed {
      logic [4:0] addr;
      logic sec_vld;
      logic [4:0] sec;
   } bch_pcb_t;

   typedef struct packed {
      logic running;
      logic pass_cmd;
      logic reqctl_cmd;
      logic task_busy;
      logic task_done;
   } bch_prog_t;

   typedef struct packed {
      bch_state_t state;
      logic [2:0] ifc_sync;
      logic ifc_act;
      logic prog_run_d;
      logic timer_en;
      logic [7:0] esr;
      logic [7:0] ese;
      logic [7:0] sre;
      bch_pcb_t pcb;
      logic pcb_err;
      logic [31:0] prdata;
      logic pslverr;
      logic srq;
      logic [7:0] stb;
   } bch_regs_t;

   typedef struct packed {
      logic [BCH_TMR_W-1:0] cnt;
      logic expired;
   } bch_tmr_t;

endpackage

// >>> rtl/bch_idle_tmr.sv
// Purpose: Idle hand-back timer, counts while allowed and flags expiry.
// Assumes: restart held high whenever control is not held.
// Notes:   Holding run low freezes the count; it never expires then.
`timescale 1ns/1ps
`default_nettype none
module bch_idle_tmr #(
   parameter int unsigned CYCLES = bch_pkg::BCH_IDLE_CYC
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic restart,
   input wire logic run,
   output var logic expired
);
   import bch_pkg::*;

   localparam logic [BCH_TMR_W-1:0] LAST = BCH_TMR_W'(CYCLES - 1);

   initial begin
      if (CYCLES < 1 || CYCLES > (2 ** BCH_TMR_W)) begin
         $error("bch_idle_tmr: CYCLES out of range");
      end
   end

   bch_tmr_t s;
   bch_tmr_t n;

   always_comb begin
      n = s;
      if (restart) begin
         n.cnt = '0; // [R14]
         n.expired = 1'b0;
      end else if (run && !s.expired) begin
         if (s.cnt == LAST) begin
            n.expired = 1'b1; // [R1]
         end else begin
            n.cnt = s.cnt + BCH_TMR_W'(1);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign expired = s.expired;

endmodule
`default_nettype wire

// >>> rtl/bch_handoff.sv
// Purpose: Controller hand-back logic: takes active control when told,
//          passes it back on timeout, task end, program command or
//          software request, and raises the request-control event.
// Assumes: Talk addressing, take-control and return-address messages
//          arrive decoded as same-clock pulses; IFC arrives on a pin.
// Notes:   APB slave with zero wait states; unmapped offsets err.
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module bch_handoff #(
   parameter int unsigned IDLE_CYCLES = bch_pkg::BCH_IDLE_CYC
) (
   input wire logic clk,
   input wire logic srst,
   input wire bch_pkg::bch_apb_req_t apb_req,
   output var bch_pkg::bch_apb_rsp_t apb_rsp,
   input wire logic ifc_n_pin,
   input wire logic talk_addressed,
   input wire logic tct_rx,
   input wire logic pcb_rx,
   input wire bch_pkg::bch_pcb_t pcb_arg,
   input wire bch_pkg::bch_prog_t prog,
   input wire logic esr_clr,
   output var bch_pkg::bch_pcb_t pass_dest,
   output var logic pass_stb,
   output var logic active_ctrl,
   output var logic [7:0] status_byte,
   output var logic srq
);
   import bch_pkg::*;

   initial begin
      if (IDLE_CYCLES < 1) begin
         $error("bch_handoff: IDLE_CYCLES must be at least one");
      end
   end

   // Address decode shared by the register writes and the
   // read-clear of the event register; the read mux decodes paddr itself.
   function automatic logic hit(input bch_apb_req_t r,
                                input logic [7:0] ofs);
      hit = r.psel && (r.paddr == ofs);
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == BCH_OFS_CTRL) || (a == BCH_OFS_STAT) ||
               (a == BCH_OFS_ESR) || (a == BCH_OFS_ESE) ||
               (a == BCH_OFS_SRE) || (a == BCH_OFS_PCB);
   endfunction

   function automatic logic addr_ok(input logic [4:0] a);
      addr_ok = (a <= BCH_ADDR_MAX);
   endfunction

   bch_regs_t s;
   bch_regs_t n;
   logic tmr_exp;
   logic tmr_restart;
   logic tmr_run;

   // Timer is cleared whenever control is not held, so every gain of
   // control starts a fresh interval.
   assign tmr_restart = (s.state != BCH_ST_ACT); // [R14]
   assign tmr_run = (s.state == BCH_ST_ACT) && !prog.running &&
                    !prog.task_busy; // [R14]

   bch_idle_tmr #(
      .CYCLES(IDLE_CYCLES)
   ) u_tmr (
      .clk(clk),
      .srst(srst),
      .restart(tmr_restart),
      .run(tmr_run),
      .expired(tmr_exp)
   );

   always_comb begin
      logic setup;
      logic access;
      logic wr;
      logic rd_esr;
      logic [7:0] clr_mask;
      logic [7:0] set_mask;
      logic [7:0] sb;
      logic prog_end;
      logic sw_release;
      logic [31:0] rdata;
      setup = 1'b0;
      access = 1'b0;
      wr = 1'b0;
      rd_esr = 1'b0;
      clr_mask = BCH_BYTE_ZERO;
      set_mask = BCH_BYTE_ZERO;
      sb = BCH_BYTE_ZERO;
      prog_end = 1'b0;
      sw_release = 1'b0;
      rdata = BCH_WORD_ZERO;
      n = s;

      // IFC pin: three stages, level moves only when the last two agree
      n.ifc_sync = {s.ifc_sync[1], s.ifc_sync[0], ifc_n_pin};
      if (s.ifc_sync[1] == s.ifc_sync[2]) begin
         n.ifc_act = ~s.ifc_sync[2];
      end

      n.prog_run_d = prog.running;
      prog_end = s.prog_run_d && !prog.running;

      setup = apb_req.psel && !apb_req.penable;
      access = apb_req.psel && apb_req.penable;
      wr = access && apb_req.pwrite;

      // Read data is captured in the setup cycle; the event register is
      // later cleared only in the bits that were actually returned, so
      // an event arriving between setup and access is not lost.
      case (apb_req.paddr)
         BCH_OFS_CTRL: begin
            rdata[BCH_CTRL_TMR_EN] = s.timer_en;
         end
         BCH_OFS_STAT: begin
            rdata[BCH_STAT_ACTIVE] = (s.state == BCH_ST_ACT);
            rdata[BCH_STAT_ST_LO +: 2] = s.state;
            rdata[BCH_STAT_IFC] = s.ifc_act;
            rdata[BCH_STAT_PROG] = prog.running;
            rdata[BCH_STAT_BUSY] = prog.task_busy;
            rdata[BCH_STAT_PCB_ERR] = s.pcb_err;
            rdata[BCH_STAT_TMR_EXP] = tmr_exp;
         end
         BCH_OFS_ESR: begin
            rdata[7:0] = s.esr;
         end
         BCH_OFS_ESE: begin
            rdata[7:0] = s.ese;
         end
         BCH_OFS_SRE: begin
            rdata[7:0] = s.sre;
         end
         BCH_OFS_PCB: begin
            rdata[BCH_PCB_ADDR_LO +: 5] = s.pcb.addr;
            rdata[BCH_PCB_SEC_VLD] = s.pcb.sec_vld;
            rdata[BCH_PCB_SEC_LO +: 5] = s.pcb.sec;
         end
         default: begin
            rdata = BCH_WORD_ZERO;
         end
      endcase
      if (setup) begin
         n.prdata = rdata;
         n.pslverr = !mapped(apb_req.paddr);
      end

      // Register writes
      if (wr && hit(apb_req, BCH_OFS_CTRL)) begin
         n.timer_en = apb_req.pwdata[BCH_CTRL_TMR_EN];
         sw_release = apb_req.pwdata[BCH_CTRL_RELEASE];
      end
      if (wr && hit(apb_req, BCH_OFS_ESE)) begin
         n.ese = apb_req.pwdata[7:0]; // [R8]
      end
      if (wr && hit(apb_req, BCH_OFS_SRE)) begin
         n.sre = apb_req.pwdata[7:0]; // [R8]
      end

      // Event status register: cleared by read or clear, set wins
      rd_esr = access && !apb_req.pwrite && hit(apb_req, BCH_OFS_ESR);
      if (rd_esr) begin
         clr_mask = s.prdata[7:0]; // [R15]
      end
      if (esr_clr) begin
         clr_mask = BCH_BYTE_ONES; // [R15]
      end
      set_mask[BCH_ESR_RQC] = prog.reqctl_cmd; // [R5]
      n.esr = (s.esr & ~clr_mask) | set_mask; // [R5] [R15]

      // Status byte and service request from the enabled summaries
      sb[BCH_STB_ESB] = |(s.esr & s.ese); // [R9]
      sb[BCH_STB_RQS] = |(sb & s.sre); // [R8]
      n.stb = sb;
      n.srq = sb[BCH_STB_RQS];

      // Return address; out-of-range arguments are dropped and flagged
      if (wr && hit(apb_req, BCH_OFS_CTRL) &&
          apb_req.pwdata[BCH_CTRL_ERR_CLR]) begin
         n.pcb_err = 1'b0;
      end
      if (pcb_rx) begin
         if (addr_ok(pcb_arg.addr) &&
             (!pcb_arg.sec_vld || addr_ok(pcb_arg.sec))) begin
            n.pcb = pcb_arg; // [R11] [R12] [R7]
         end else begin
            n.pcb_err = 1'b1; // [R12]
         end
      end

      // Control state machine
      case (s.state)
         BCH_ST_IDLE: begin
            if (talk_addressed) begin
               n.state = BCH_ST_ADDR; // [R13]
            end
         end
         BCH_ST_ADDR: begin
            if (s.ifc_act) begin
               n.state = BCH_ST_IDLE;
            end else if (tct_rx) begin
               n.state = BCH_ST_ACT; // [R13]
            end else if (!talk_addressed) begin
               n.state = BCH_ST_IDLE;
            end
         end
         BCH_ST_ACT: begin
            if (s.ifc_act) begin
               // System controller already owns the bus: no pass
               n.state = BCH_ST_IDLE; // [R2]
            end else if (prog.running && prog.pass_cmd) begin
               n.state = BCH_ST_PASS; // [R4]
            end else if (!prog.running && prog.task_done) begin
               n.state = BCH_ST_PASS; // [R3]
            end else if (tmr_exp && s.timer_en && !prog.running &&
                         !prog.task_busy) begin
               n.state = BCH_ST_PASS; // [R1]
            end else if (prog_end || sw_release) begin
               n.state = BCH_ST_PASS;
            end
         end
         BCH_ST_PASS: begin
            n.state = BCH_ST_IDLE;
         end
         default: begin
            n.state = BCH_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s.state <= BCH_ST_IDLE;
         s.ifc_sync <= BCH_IFC_SYNC_RST;
         s.ifc_act <= 1'b0;
         s.prog_run_d <= 1'b0;
         s.timer_en <= BCH_TMR_EN_RST;
         s.esr <= BCH_BYTE_ZERO;
         s.ese <= BCH_BYTE_ZERO;
         s.sre <= BCH_BYTE_ZERO;
         s.pcb.addr <= BCH_ADDR_DFLT; // [R11]
         s.pcb.sec_vld <= 1'b0;
         s.pcb.sec <= BCH_ADDR_DFLT;
         s.pcb_err <= 1'b0;
         s.prdata <= BCH_WORD_ZERO;
         s.pslverr <= 1'b0;
         s.srq <= 1'b0;
         s.stb <= BCH_BYTE_ZERO;
      end else begin
         s <= n;
      end
   end

   // Zero wait states: every access completes at its first access edge
   assign apb_rsp.prdata = s.prdata;
   assign apb_rsp.pready = 1'b1;
   assign apb_rsp.pslverr = s.pslverr;

   // Destination is held stable while the pass strobe is out
   assign pass_dest = s.pcb; // [R11]
   assign pass_stb = (s.state == BCH_ST_PASS);
   assign active_ctrl = (s.state == BCH_ST_ACT);
   assign status_byte = s.stb;
   assign srq = s.srq;

endmodule
`default_nettype wire

// >>> tb/bch_handoff_chk.sv
// Purpose: Port timing checks for bch_handoff.
// Assumes: Sync reset srst; pulses last one cycle.
// Notes: Idle bound leaves slack for the timer and state pipeline.
`timescale 1ns/1ps
`default_nettype none
module bch_handoff_chk
   import bch_pkg::*;
#(parameter int unsigned IDLE_CYCLES = 50) (
   input wire logic clk,
   input wire logic srst,
   input wire bch_pkg::bch_apb_req_t apb_req,
   input wire bch_pkg::bch_apb_rsp_t apb_rsp,
   input wire logic ifc_n_pin,
   input wire logic talk_addressed,
   input wire logic tct_rx,
   input wire logic pcb_rx,
   input wire bch_pkg::bch_pcb_t pcb_arg,
   input wire bch_pkg::bch_prog_t prog,
   input wire logic esr_clr,
   input wire bch_pkg::bch_pcb_t pass_dest,
   input wire logic pass_stb,
   input wire logic active_ctrl,
   input wire logic [7:0] status_byte,
   input wire logic srq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   int unsigned idle_cnt_ff;
   always_ff @(posedge clk) begin
      if (srst || !active_ctrl) begin
         idle_cnt_ff <= 0;
      end else if (!prog.running && !prog.task_busy) begin
         idle_cnt_ff <= idle_cnt_ff + 1;
      end
   end
   sequence s_ifc_low;
      !ifc_n_pin [*6];
   endsequence
   sequence s_hand_back;
      pass_stb ##0 $fell(active_ctrl);
   endsequence
   a_take_ctrl: assert property ($rose(active_ctrl) |-> $past(tct_rx))
      else $error("control taken without take-control");
   a_hand_edge: assert property ($rose(pass_stb) |-> s_hand_back)
      else $error("pass strobe without loss of control");
   a_pcb_load: assert property (pcb_rx && pcb_arg.addr <= BCH_ADDR_MAX
      && (!pcb_arg.sec_vld || pcb_arg.sec <= BCH_ADDR_MAX)
      |=> pass_dest == $past(pcb_arg)) else $error("return address lost");
   a_pcb_refuse: assert property (pcb_rx && pcb_arg.addr > BCH_ADDR_MAX
      |=> $stable(pass_dest)) else $error("bad return address taken");
   a_ifc_drop: assert property (s_ifc_low |-> !active_ctrl && !pass_stb)
      else $error("control kept under interface clear");
   a_task_end: assert property (active_ctrl && prog.task_done
      && !prog.running && ifc_n_pin |=> s_hand_back)
      else $error("no hand-back after task end");
   a_pass_cmd: assert property (active_ctrl && prog.running
      && prog.pass_cmd && ifc_n_pin |=> s_hand_back)
      else $error("no hand-back on program command");
   a_idle_bound: assert property (idle_cnt_ff <= IDLE_CYCLES + 3)
      else $error("idle control held too long");
   a_stb_pulse: assert property (pass_stb |=> !pass_stb)
      else $error("pass strobe longer than one cycle");
   a_bad_ofs: assert property (apb_req.psel && apb_req.penable
      && apb_req.paddr > BCH_OFS_PCB |-> apb_rsp.pslverr)
      else $error("unmapped offset without error");
endmodule
bind bch_handoff bch_handoff_chk #(.IDLE_CYCLES(IDLE_CYCLES)) bch_handoff_chk_i (
   .clk(clk), .srst(srst), .apb_req(apb_req), .apb_rsp(apb_rsp),
   .ifc_n_pin(ifc_n_pin), .talk_addressed(talk_addressed),
   .tct_rx(tct_rx), .pcb_rx(pcb_rx), .pcb_arg(pcb_arg), .prog(prog),
   .esr_clr(esr_clr), .pass_dest(pass_dest), .pass_stb(pass_stb),
   .active_ctrl(active_ctrl), .status_byte(status_byte), .srq(srq)
);
`default_nettype wire

// >>> tb/bch_ext_ctl.sv
// Purpose: Far-side active controller that passes control in.
// Assumes: give pulses one cycle; ret holds while a pass runs.
// Notes: Acts on give or on a rising srq with status bit 5 set, so one request is served once.
`timescale 1ns/1ps
`default_nettype none
module bch_ext_ctl
   import bch_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic give,
   input wire bch_pkg::bch_pcb_t ret,
   input wire logic [3:0] gap,
   input wire logic ifc_req,
   input wire logic srq,
   input wire logic [7:0] status_byte,
   output logic talk_addressed,
   output logic tct_rx,
   output logic pcb_rx,
   output bch_pkg::bch_pcb_t pcb_arg,
   output logic ifc_n_pin
);
   logic srq_d = 1'b0;
   logic poll;
   assign ifc_n_pin = !ifc_req;
   task automatic pass_seq();
      pcb_rx <= 1'b1;
      pcb_arg <= ret;
      @(posedge clk);
      pcb_rx <= 1'b0;
      // Released lines show no stale address
      pcb_arg <= ~ret;
      repeat (gap) @(posedge clk);
      // Remote enable never asserted, so the device is local here
      talk_addressed <= 1'b1;
      @(posedge clk);
      tct_rx <= 1'b1;
      @(posedge clk);
      tct_rx <= 1'b0;
      talk_addressed <= 1'b0;
   endtask
   initial begin
      talk_addressed = 1'b0;
      tct_rx = 1'b0;
      pcb_rx = 1'b0;
      pcb_arg = '0;
      forever begin
         @(posedge clk);
         poll = srq && !srq_d && status_byte[BCH_STB_ESB];
         srq_d = srq;
         if (!srst && (give || poll)) begin
            pass_seq();
         end
      end
   end
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Purpose: Self-checking bench for bch_handoff.
// Assumes: Idle count shortened to 50 cycles.
// Notes: Far-side controller runs in bch_ext_ctl.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import bch_pkg::*;
   localparam int unsigned IDLE = 50;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic esr_clr = 1'b0;
   logic give = 1'b0;
   logic ifc_req = 1'b0;
   logic [3:0] gap = 4'h0;
   bch_apb_req_t apb_req = '0;
   bch_prog_t prog = '0;
   bch_pcb_t ret = '0;
   bch_pcb_t good, bad, pcb_arg, pass_dest;
   bch_apb_rsp_t apb_rsp;
   logic ifc_n_pin, talk_addressed, tct_rx, pcb_rx;
   logic pass_stb, active_ctrl, srq, seen, err;
   logic [7:0] status_byte;
   logic [31:0] rd;
   int errors = 0;
   int samples_checked = 0;
   time t0;
   always #10 clk = ~clk;
   bch_handoff #(.IDLE_CYCLES(IDLE)) bch_handoff_i (
      .clk(clk), .srst(srst), .apb_req(apb_req), .apb_rsp(apb_rsp),
      .ifc_n_pin(ifc_n_pin), .talk_addressed(talk_addressed),
      .tct_rx(tct_rx), .pcb_rx(pcb_rx), .pcb_arg(pcb_arg), .prog(prog),
      .esr_clr(esr_clr), .pass_dest(pass_dest), .pass_stb(pass_stb),
      .active_ctrl(active_ctrl), .status_byte(status_byte), .srq(srq)
   );
   bch_ext_ctl bch_ext_ctl_i (
      .clk(clk), .srst(srst), .give(give), .ret(ret), .gap(gap),
      .ifc_req(ifc_req), .srq(srq), .status_byte(status_byte),
      .talk_addressed(talk_addressed), .tct_rx(tct_rx), .pcb_rx(pcb_rx),
      .pcb_arg(pcb_arg), .ifc_n_pin(ifc_n_pin)
   );
   task automatic report_and_stop();
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", what, exp, got);
         errors++;
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] wd);
      int k;
      k = 0;
      apb_req <= '{a, 1'b1, 1'b0, w, wd};
      @(posedge clk);
      apb_req.penable <= 1'b1;
      @(posedge clk);
      while (apb_rsp.pready !== 1'b1) begin
         k++;
         if (k > 20) begin
            errors++;
            report_and_stop();
         end
         @(posedge clk);
      end
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                         input logic e);
      apb(1'b0, a, 32'h0000_0000);
      chk("prdata", exp, rd);
      chk("pslverr", 32'(e), 32'(err));
   endtask
   task automatic wait_on(input logic on_pass, input int lim);
      int k;
      k = 0;
      while ((on_pass ? pass_stb : active_ctrl) !== 1'b1) begin
         k++;
         if (k > lim) begin
            errors++;
            report_and_stop();
         end
         @(posedge clk);
         #1;
      end
   endtask
   // Caller is edge aligned; returns 1 ns after control is held
   task automatic hand(input bch_pcb_t r, input logic [3:0] g);
      ret <= r;
      gap <= g;
      give <= 1'b1;
      @(posedge clk);
      give <= 1'b0;
      #1;
      wait_on(1'b0, 40);
   endtask
   function automatic bch_pcb_t rnd_pcb();
      rnd_pcb.addr = 5'($urandom_range(30));
      rnd_pcb.sec_vld = 1'($urandom_range(1));
      rnd_pcb.sec = 5'($urandom_range(30));
   endfunction
   function automatic logic [31:0] pcb_word(input bch_pcb_t r);
      return {11'h000, r.sec, 7'h00, r.sec_vld, 3'h0, r.addr};
   endfunction
   function automatic logic in_win(input longint c, input int k);
      return (c >= IDLE + 20 * k) && (c <= IDLE + 20 * k + 4);
   endfunction
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      report_and_stop();
   end
   initial begin
      t0 = $urandom(32'ha1874aae);
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      rd_chk(BCH_OFS_CTRL, 32'h0000_0001, 1'b0);
      rd_chk(BCH_OFS_STAT, 32'h0000_0000, 1'b0);
      rd_chk(BCH_OFS_ESR, 32'h0000_0000, 1'b0);
      rd_chk(BCH_OFS_PCB, 32'h0000_0000, 1'b0);
      rd_chk(8'h18, 32'h0000_0000, 1'b1);
      esr_clr <= 1'b1;
      @(posedge clk);
      esr_clr <= 1'b0;
      apb(1'b1, BCH_OFS_ESE, 32'h0000_0002);
      apb(1'b1, BCH_OFS_SRE, 32'h0000_0020);
      rd_chk(BCH_OFS_SRE, 32'h0000_0020, 1'b0);
      good = rnd_pcb();
      ret <= good;
      prog.running <= 1'b1;
      prog.reqctl_cmd <= 1'b1;
      @(posedge clk);
      prog.reqctl_cmd <= 1'b0;
      #1;
      wait_on(1'b0, 60);
      chk("pass_dest", 32'(good), 32'(pass_dest));
      chk("status_byte", 32'h0000_0060, 32'(status_byte));
      chk("srq", 32'h0000_0001, 32'(srq));
      @(posedge clk);
      rd_chk(BCH_OFS_ESR, 32'h0000_0002, 1'b0);
      rd_chk(BCH_OFS_ESR, 32'h0000_0000, 1'b0);
      chk("srq", 32'h0000_0000, 32'(srq));
      chk("status_byte", 32'h0000_0000, 32'(status_byte));
      prog.pass_cmd <= 1'b1;
      @(posedge clk);
      prog.pass_cmd <= 1'b0;
      #1;
      chk("pass_stb", 32'h0000_0001, 32'(pass_stb));
      chk("active_ctrl", 32'h0000_0000, 32'(active_ctrl));
      @(posedge clk);
      prog.running <= 1'b0;
      prog.task_busy <= 1'b1;
      good = rnd_pcb();
      hand(good, 4'($urandom_range(15)));
      repeat (IDLE + 20) @(posedge clk);
      chk("active_ctrl", 32'h0000_0001, 32'(active_ctrl));
      prog.task_busy <= 1'b0;
      prog.task_done <= 1'b1;
      @(posedge clk);
      prog.task_done <= 1'b0;
      #1;
      chk("pass_stb", 32'h0000_0001, 32'(pass_stb));
      chk("pass_dest", 32'(good), 32'(pass_dest));
      // Second pass freezes the timer for 20 cycles mid-count
      for (int k = 0; k < 2; k++) begin
         @(posedge clk);
         good = rnd_pcb();
         hand(good, 4'($urandom_range(15)));
         t0 = $time;
         if (k == 1) begin
            @(posedge clk);
            prog.task_busy <= 1'b1;
            repeat (20) @(posedge clk);
            prog.task_busy <= 1'b0;
            #1;
         end
         wait_on(1'b1, IDLE + 40);
         chk("idle_win", 32'h1, 32'(in_win(($time - t0) / 20, k)));
      end
      @(posedge clk);
      prog.running <= 1'b1;
      hand(good, 4'h0);
      @(posedge clk);
      ifc_req <= 1'b1;
      seen = 1'b0;
      repeat (8) begin
         @(posedge clk);
         #1;
         seen = seen | (pass_stb !== 1'b0);
      end
      chk("ifc_pass_stb", 32'h0000_0000, 32'(seen));
      chk("active_ctrl", 32'h0000_0000, 32'(active_ctrl));
      @(posedge clk);
      ifc_req <= 1'b0;
      prog.running <= 1'b0;
      repeat (4) @(posedge clk);
      rd_chk(BCH_OFS_ESE, 32'h0000_0002, 1'b0);
      rd_chk(BCH_OFS_PCB, pcb_word(good), 1'b0);
      for (int k = 0; k < 2; k++) begin
         bad = (k == 0) ? 11'h7c0 : 11'h07f;
         hand(bad, 4'h2);
         @(posedge clk);
         apb(1'b0, BCH_OFS_STAT, 32'h0000_0000);
         chk("pcb_err", 32'h1, 32'(rd[BCH_STAT_PCB_ERR]));
         chk("pass_dest", 32'(good), 32'(pass_dest));
         apb(1'b1, BCH_OFS_CTRL, 32'h0000_0003);
         #1;
         chk("active_ctrl", 32'h0000_0000, 32'(active_ctrl));
         @(posedge clk);
         apb(1'b1, BCH_OFS_CTRL, 32'h0000_0005);
         apb(1'b0, BCH_OFS_STAT, 32'h0000_0000);
         chk("pcb_err", 32'h0, 32'(rd[BCH_STAT_PCB_ERR]));
      end
      report_and_stop();
   end
endmodule
`default_nettype wire
